/* File: core/cnt16.sv */
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module cnt16
   import cnt16_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire bus_req_t bus,
   output logic [7:0] rdata,
   input wire logic ext_clk_in,
   input wire logic osc_clk_in,
   input wire logic [1:0] port_pins_in,
   input wire logic [1:0] port_direction_bits,
   input wire logic sleep_exec,
   input wire logic wake_event,
   input wire logic special_trigger,
   input wire logic [3:0] compare_unit_mode_field,
   input wire logic compare_uses_timer,
   output logic low_power_osc_run,
   output logic [1:0] osc_pins_oe,
   output logic overflow_irq,
   output logic sysclk_from_osc,
   output logic cpu_clock_gate
);
   ////////////////////////////////////////////////////////////////
   logic [7:0] control;
   logic [7:0] count_low_byte;
   logic [7:0] count_high_byte;
   logic [7:0] high_buffer;
   logic overflow_flag;
   logic overflow_irq_enable;
   logic idle_on_sleep_enable;
   logic [1:0] system_clock_select;
   pm_state_t pm_state;
   pm_state_t next_pm_state;
   logic [1:0] instr_div;
   logic [2:0] prescaler;
   logic [2:0] ext_sync;
   logic [2:0] pin_sync0;
   logic [2:0] pin_sync1;
   logic src_prev;

   wire counter_on = control[BIT_ON];
   wire count_source_select = control[BIT_SRC];
   wire ext_clock_sync_select = control[BIT_SYNC];
   wire low_power_osc_enable = control[BIT_OSCEN];
   wire [1:0] input_prescale_select = control[BIT_PS_LO+1:BIT_PS_LO];
   wire wide_access_enable = control[BIT_WIDE];
   wire osc_drives_sysclk_flag = (pm_state == PM_SEC_RUN) || (pm_state == PM_SEC_IDLE);

   wire wr_ctl = bus.wr && bus.addr == ADDR_CONTROL;
   wire wr_low = bus.wr && bus.addr == ADDR_LOW;
   wire wr_high = bus.wr && bus.addr == ADDR_HIGH;
   wire wr_flags = bus.wr && bus.addr == ADDR_IRQ_FLAGS;
   wire wr_ien = bus.wr && bus.addr == ADDR_IRQ_ENABLE;
   wire wr_osc = bus.wr && bus.addr == ADDR_OSC_CONTROL;
   wire rd_low = bus.rd && bus.addr == ADDR_LOW;

   ////////////////////////////////////////////////////////////////
   // The oscillator is a pin in this model; edges are only trusted once the
   // second and third stages agree, while the unsynchronised path does not wait.
   wire osc_src = low_power_osc_enable ? osc_clk_in : ext_clk_in;
   wire ext_edge = ext_sync[1] && ext_sync[2] && !src_prev;
   // Unsynchronised counting takes the edge one stage earlier; software must
   // not rely on trigger reset there because the edge may race it.
   wire ext_edge_async = ext_sync[1] && !ext_sync[2];
   wire instr_tick = instr_div == INSTR_DIV_LAST;
   wire src_tick = count_source_select ? (ext_clock_sync_select ? ext_edge_async : ext_edge)
                                       : instr_tick;
   wire [2:0] ps_mask = (3'h1 << input_prescale_select) - 3'h1;
   wire ps_tick = counter_on && src_tick && ((prescaler & ps_mask) == ps_mask);
   wire [16:0] count_inc = {1'b0, count_high_byte, count_low_byte} + 17'h1;
   wire wrap = ps_tick && {count_high_byte, count_low_byte} == COUNT_MAX;
   wire trig_reset = special_trigger && compare_uses_timer &&
                     compare_unit_mode_field == MODE_SPECIAL_TRIGGER;
   wire sw_count_write = wr_low || (wr_high && !wide_access_enable);

   ////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ext_sync <= 3'h0;
         pin_sync0 <= 3'h0;
         pin_sync1 <= 3'h0;
         src_prev <= 1'b0;
         instr_div <= 2'h0;
      end else begin
         ext_sync <= {ext_sync[1:0], osc_src};
         pin_sync0 <= {pin_sync0[1:0], port_pins_in[0]};
         pin_sync1 <= {pin_sync1[1:0], port_pins_in[1]};
         if (ext_sync[1] == ext_sync[2]) begin
            src_prev <= ext_sync[2];
         end
         instr_div <= instr_div + 2'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst || wr_low) begin
         prescaler <= 3'h0;
      end else if (counter_on && src_tick) begin
         prescaler <= prescaler + 3'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         control <= CONTROL_RESET;
      end else if (wr_ctl) begin
         control <= {bus.wdata[7], 1'b0, bus.wdata[5:0]};
      end
   end

   ////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         count_low_byte <= COUNT_RESET[7:0];
         count_high_byte <= COUNT_RESET[15:8];
         high_buffer <= 8'h00;
      end else begin
         if (sw_count_write) begin
            if (wr_low) begin
               count_low_byte <= bus.wdata;
               if (wide_access_enable) begin
                  count_high_byte <= high_buffer;
               end
            end else begin
               count_high_byte <= bus.wdata;
            end
         end else if (trig_reset) begin
            count_low_byte <= COUNT_RESET[7:0];
            count_high_byte <= COUNT_RESET[15:8];
         end else if (ps_tick) begin
            count_low_byte <= count_inc[7:0];
            count_high_byte <= count_inc[15:8];
         end
         if (wr_high && wide_access_enable) begin
            high_buffer <= bus.wdata;
         end else if (rd_low && wide_access_enable) begin
            high_buffer <= count_high_byte;
         end
      end
   end

   // Trigger reset overrides the tick, so a wrap under it never flags.
   wire ovf_event = wrap && !sw_count_write && !trig_reset;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         overflow_flag <= 1'b0;
         overflow_irq_enable <= 1'b0;
         overflow_irq <= 1'b0;
      end else begin
         if (ovf_event) begin
            overflow_flag <= 1'b1;
         end else if (wr_flags) begin
            overflow_flag <= bus.wdata[0];
         end
         if (wr_ien) begin
            overflow_irq_enable <= bus.wdata[0];
         end
         overflow_irq <= (overflow_flag || ovf_event) && overflow_irq_enable;
      end
   end

   ////////////////////////////////////////////////////////////////
   always_comb begin
      next_pm_state = pm_state;
      case (pm_state)
         PM_RUN: begin
            if (system_clock_select == SCS_TIMER_OSC) begin
               next_pm_state = PM_SEC_RUN;
            end else if (sleep_exec) begin
               next_pm_state = PM_SLEEP;
            end
         end
         PM_SEC_RUN: begin
            if (system_clock_select != SCS_TIMER_OSC) begin
               next_pm_state = PM_RUN;
            end else if (sleep_exec) begin
               next_pm_state = idle_on_sleep_enable ? PM_SLEEP : PM_SEC_IDLE;
            end
         end
         PM_SEC_IDLE: begin
            if (wake_event) begin
               next_pm_state = PM_SEC_RUN;
            end
         end
         PM_SLEEP: begin
            if (wake_event) begin
               next_pm_state = (system_clock_select == SCS_TIMER_OSC) ? PM_SEC_RUN : PM_RUN;
            end
         end
         default: begin
            next_pm_state = PM_RUN;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pm_state <= PM_RUN;
         system_clock_select <= 2'h0;
         idle_on_sleep_enable <= 1'b0;
      end else begin
         pm_state <= next_pm_state;
         if (wr_osc) begin
            system_clock_select <= bus.wdata[1:0];
            idle_on_sleep_enable <= bus.wdata[BIT_IDLE_ON_SLEEP_ENABLE];
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // The oscillator enable ignores the power state, so it runs through
   // every sleep and idle mode; start-up delay is left to software.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         low_power_osc_run <= 1'b0;
         osc_pins_oe <= 2'h0;
         sysclk_from_osc <= 1'b0;
         cpu_clock_gate <= 1'b1;
      end else begin
         low_power_osc_run <= low_power_osc_enable;
         osc_pins_oe <= counter_on ? 2'h0 : ~port_direction_bits;
         sysclk_from_osc <= osc_drives_sysclk_flag;
         cpu_clock_gate <= (next_pm_state == PM_RUN) || (next_pm_state == PM_SEC_RUN);
      end
   end

   wire [7:0] port_read = counter_on ? 8'h00 : {6'h00, pin_sync1[2], pin_sync0[2]};
   wire [7:0] control_read = {control[7], osc_drives_sysclk_flag, control[5:0]};
   wire [7:0] high_read = wide_access_enable ? high_buffer : count_high_byte;
   wire [7:0] read_mux =
      (bus.addr == ADDR_CONTROL) ? control_read :
      (bus.addr == ADDR_LOW) ? count_low_byte :
      (bus.addr == ADDR_HIGH) ? high_read :
      (bus.addr == ADDR_IRQ_FLAGS) ? {7'h00, overflow_flag} :
      (bus.addr == ADDR_IRQ_ENABLE) ? {7'h00, overflow_irq_enable} :
      (bus.addr == ADDR_OSC_CONTROL) ? {idle_on_sleep_enable, 5'h00, system_clock_select} :
      (bus.addr == ADDR_PORT) ? port_read : 8'h00;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rdata <= 8'h00;
      end else begin
         rdata <= bus.rd ? read_mux : 8'h00;
      end
   end
endmodule
`default_nettype wire

/* File: core/cnt16_pkg.sv */
// Contract
// - Source select and sync bits pick timer, synchronous counter or asynchronous counter operation.
// - Source select 0 counts one tick per instruction cycle (clock divided by four).
// - Source select 1 counts rising edges of external pin or oscillator when enabled.
// - While on, both oscillator pins are inputs and read as zero on the port.
// - Wide access enable maps the high byte address onto a buffer register.
// - In wide mode a low byte read copies the live high byte into the buffer.
// - In wide mode high writes go to buffer, moved to counter on low write.
// - In wide mode the live high byte has no direct read or write path.
// - Low byte writes clear the prescaler; high byte writes leave it alone.
// - Oscillator enable bit turns the low-power oscillator on, clearing it turns it off.
// - Once enabled, the oscillator keeps running in every power-managed mode.
// - System clock select 01 clocks CPU and peripherals from the timer oscillator.
// - Idle enable clear plus sleep while on the timer oscillator enters secondary idle.
// - Read-only status bit 6 is set while the timer oscillator drives the system clock.
// - The sixteen-bit pair counts up from 0000h to FFFFh then wraps to 0000h.
// - Each overflow sets and holds the overflow flag, bit 0 of the flag register.
// - An overflow interrupt request is raised only when enable bit 0 is set.
// - A compare unit special event trigger resets the counter.
// - A software counter write in the same cycle as a trigger wins over the reset.
// - A trigger reset never sets the overflow flag.
// - Counter on bit 0 enables counting; clearing it stops counting.
// - Prescale field bits 5:4 selects 1:1, 1:2, 1:4 or 1:8.
// - External source is synchronised while the sync bit is clear; ignored for internal clock.
package cnt16_pkg;
   localparam logic [2:0] ADDR_CONTROL = 3'h0;
   localparam logic [2:0] ADDR_LOW = 3'h1;
   localparam logic [2:0] ADDR_HIGH = 3'h2;
   localparam logic [2:0] ADDR_IRQ_FLAGS = 3'h3;
   localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h4;
   localparam logic [2:0] ADDR_OSC_CONTROL = 3'h5;
   localparam logic [2:0] ADDR_PORT = 3'h6;
   localparam int BIT_ON = 0;
   localparam int BIT_SRC = 1;
   localparam int BIT_SYNC = 2;
   localparam int BIT_OSCEN = 3;
   localparam int BIT_PS_LO = 4;
   localparam int BIT_RUN = 6;
   localparam int BIT_WIDE = 7;
   localparam int BIT_IDLE_ON_SLEEP_ENABLE = 7;
   localparam logic [1:0] SCS_TIMER_OSC = 2'h1;
   localparam logic [3:0] MODE_SPECIAL_TRIGGER = 4'hB;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;
   typedef enum logic [1:0] {
      PM_RUN = 2'b00,
      PM_SEC_RUN = 2'b01,
      PM_SEC_IDLE = 2'b10,
      PM_SLEEP = 2'b11
   } pm_state_t;
endpackage

/* File: bench/cnt16_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module cnt16_checker
   import cnt16_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire bus_req_t bus,
   input wire logic [7:0] rdata,
   input wire logic sleep_exec,
   input wire logic [1:0] osc_pins_oe,
   input wire logic low_power_osc_run,
   input wire logic overflow_irq,
   input wire logic sysclk_from_osc,
   input wire logic cpu_clock_gate
);
   logic [7:0] ctl;
   logic ie, idl;
   wire logic wr_ctl = bus.wr && bus.addr == ADDR_CONTROL;
   // Shadow copies of the written settings, so outputs can be tied to their causes.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctl <= CONTROL_RESET;
         ie <= 1'b0;
         idl <= 1'b0;
      end else begin
         ctl <= wr_ctl ? bus.wdata : ctl;
         ie <= (bus.wr && bus.addr == ADDR_IRQ_ENABLE) ? bus.wdata[0] : ie;
         idl <= (bus.wr && bus.addr == ADDR_OSC_CONTROL) ? bus.wdata[BIT_IDLE_ON_SLEEP_ENABLE] : idl;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence s_sleep_sec; sysclk_from_osc && !idl && sleep_exec; endsequence
   sequence s_sec_idle; sysclk_from_osc && !cpu_clock_gate; endsequence
   property p_oe_in; !$past(sys_rst) && $past(ctl[BIT_ON]) |-> osc_pins_oe == 2'h0; endproperty
   property p_port0; $past(bus.rd && bus.addr == ADDR_PORT && ctl[BIT_ON]) |-> rdata[1:0] == 2'h0; endproperty
   property p_osc_en; !$past(sys_rst) |-> low_power_osc_run == $past(ctl[BIT_OSCEN]); endproperty
   property p_osc_keep; ctl[BIT_OSCEN] && $past(ctl[BIT_OSCEN]) && !cpu_clock_gate |-> low_power_osc_run; endproperty
   property p_sec_run;
      cpu_clock_gate && bus.wr && bus.addr == ADDR_OSC_CONTROL && bus.wdata[1:0] == SCS_TIMER_OSC
         |-> ##[1:3] sysclk_from_osc;
   endproperty
   property p_sec_idle; s_sleep_sec |-> ##[1:3] s_sec_idle; endproperty
   property p_run_flag;
      $past(bus.rd && bus.addr == ADDR_CONTROL) && $stable(sysclk_from_osc)
         && $past(sysclk_from_osc, 2) == sysclk_from_osc |-> rdata[BIT_RUN] == sysclk_from_osc;
   endproperty
   property p_irq_en; !$past(sys_rst) && overflow_irq |-> $past(ie); endproperty
   a_oe_in: assert property (p_oe_in) else $error("pin driven while counting");
   a_port0: assert property (p_port0) else $error("pins not read as zero");
   a_osc_en: assert property (p_osc_en) else $error("oscillator run wrong");
   a_osc_keep: assert property (p_osc_keep) else $error("oscillator stopped in low power");
   a_sec_run: assert property (p_sec_run) else $error("no switch to oscillator clock");
   a_sec_idle: assert property (p_sec_idle) else $error("no secondary idle");
   a_run_flag: assert property (p_run_flag) else $error("status bit wrong");
   a_irq_en: assert property (p_irq_en) else $error("request while disabled");
endmodule
////////////////////////////////////////
bind cnt16 cnt16_checker u_chk (.mclk(mclk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
   .sleep_exec(sleep_exec), .osc_pins_oe(osc_pins_oe), .low_power_osc_run(low_power_osc_run),
   .overflow_irq(overflow_irq), .sysclk_from_osc(sysclk_from_osc), .cpu_clock_gate(cpu_clock_gate));
`default_nettype wire

/* File: bench/far_side.sv */
`timescale 1ns/1ps
`default_nettype none
module far_side (
   input wire logic mclk,
   input wire logic osc_on,
   input wire logic [3:0] half,
   input wire logic go,
   input wire logic [7:0] n_edges,
   output logic ext_clk,
   output logic osc_clk,
   output logic busy
);
   logic [8:0] left = 9'h000;
   logic [3:0] ph = 4'h0;
   logic e = 1'b0;
   logic o = 1'b0;
   wire logic step = ph >= half;
   assign busy = left != 9'h000;
   assign ext_clk = e;
   assign osc_clk = o;
   // The external clock stands low between bursts, as a gated source would.
   always @(posedge mclk) begin
      ph <= step ? 4'h0 : ph + 4'h1;
      if (go)
         left <= {n_edges, 1'b0};
      else if (step && busy) begin
         left <= left - 9'h001;
         e <= ~e;
      end
      if (step)
         o <= osc_on & ~o;
   end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import cnt16_pkg::*;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   bus_req_t bus = '0;
   logic [7:0] rdata, d, n = 8'h00;
   logic [15:0] v, w;
   logic [2:0] pm = 3'h0;
   logic [3:0] mode = MODE_SPECIAL_TRIGGER, half = 4'h3;
   logic [1:0] pins = 2'h0, dir = 2'h3, oe;
   logic use_t = 1'b1, go = 1'b0, busy, ext, osc, run, irq, from_osc, gate;
   int err_count = 0, tests_run = 0, cyc = 0, i;
   cnt16 i_dut (.mclk(mclk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .ext_clk_in(ext),
      .osc_clk_in(osc), .port_pins_in(pins), .port_direction_bits(dir), .sleep_exec(pm[0]),
      .wake_event(pm[1]), .special_trigger(pm[2]), .compare_unit_mode_field(mode),
      .compare_uses_timer(use_t), .low_power_osc_run(run), .osc_pins_oe(oe), .overflow_irq(irq),
      .sysclk_from_osc(from_osc), .cpu_clock_gate(gate));
   far_side i_far (.mclk(mclk), .osc_on(run), .half(half), .go(go), .n_edges(n), .ext_clk(ext),
      .osc_clk(osc), .busy(busy));
   initial forever #2.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         test_done;
      end
   end
   ////////////////////////////////////////
   // Writes carry the sleep, wake and trigger pulses, to the unmapped address or, for the trigger race, to the low byte.
   task automatic wr(input logic [2:0] a, input logic [7:0] x, input logic [2:0] p = 3'h0);
      @(posedge mclk);
      bus <= '{a, x, 1'b1, 1'b0};
      pm <= p;
      @(posedge mclk);
      bus <= '0;
      pm <= 3'h0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] x);
      @(posedge mclk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge mclk);
      bus <= '0;
      #1 x = rdata;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
      end
   endtask
   // The tick divider phase is free, so a timed count may be one off either way.
   task automatic near(input logic [15:0] exp);
      rd(ADDR_LOW, w[7:0]);
      rd(ADDR_HIGH, w[15:8]);
      tests_run++;
      if (^w === 1'bx || w + 16'h1 < exp || w > exp + 16'h1) begin
         err_count++;
         $display("[FAIL] %0t count %h expected %h", $time, w, exp);
      end
   endtask
   task automatic edges(input logic [7:0] k);
      @(posedge mclk);
      n <= k;
      go <= 1'b1;
      half <= 4'($urandom_range(8, 3));
      @(posedge mclk);
      go <= 1'b0;
      for (i = 0; i < 3000 && (busy || i < 2); i++) @(posedge mclk);
      repeat (10) @(posedge mclk);
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      void'($urandom(32'hB8088E18));
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      rd(ADDR_CONTROL, d);
      chk(d, CONTROL_RESET);
      wr(ADDR_CONTROL, 8'hFF);
      dir <= 2'($urandom);
      pins <= 2'($urandom);
      rd(ADDR_CONTROL, d);
      chk(d, 8'hBF);
      rd(ADDR_PORT, d);
      chk(d, 8'h00);
      chk({6'h00, oe}, 8'h00);
      rd(3'h7, d);
      chk(d, 8'h00);
      for (int ps = 0; ps < 4; ps++) begin
         v = 16'($urandom_range(12, 3));
         wr(ADDR_CONTROL, 8'h00);
         wr(ADDR_HIGH, 8'h00);
         wr(ADDR_LOW, 8'h00);
         wr(ADDR_CONTROL, {2'b00, 2'(ps), 4'h1});
         repeat ((int'(v) * 4) << ps) @(posedge mclk);
         wr(ADDR_CONTROL, 8'h00);
         near(v);
      end
      repeat (40) @(posedge mclk);
      rd(ADDR_LOW, d);
      chk(d, w[7:0]);
      rd(ADDR_PORT, d);
      chk(d, {6'h00, pins});
      chk({6'h00, oe}, {6'h00, ~dir});
      v = 16'($urandom);
      wr(ADDR_CONTROL, 8'h80);
      wr(ADDR_HIGH, v[15:8]);
      wr(ADDR_LOW, v[7:0]);
      wr(ADDR_HIGH, ~v[15:8]);
      rd(ADDR_HIGH, d);
      chk(d, ~v[15:8]);
      rd(ADDR_LOW, d);
      chk(d, v[7:0]);
      rd(ADDR_HIGH, d);
      chk(d, v[15:8]);
      wr(ADDR_HIGH, 8'h12);
      wr(ADDR_CONTROL, 8'h81);
      wr(ADDR_LOW, 8'hFE);
      rd(ADDR_LOW, d);
      repeat (40) @(posedge mclk);
      rd(ADDR_HIGH, d);
      chk(d, 8'h12);
      rd(ADDR_LOW, d);
      rd(ADDR_HIGH, d);
      chk(d, 8'h13);
      wr(ADDR_CONTROL, 8'h80);
      wr(ADDR_IRQ_ENABLE, 8'h00);
      wr(ADDR_HIGH, 8'hFF);
      wr(ADDR_LOW, 8'hFE);
      wr(ADDR_IRQ_FLAGS, 8'h00);
      wr(ADDR_CONTROL, 8'h81);
      repeat (14) @(posedge mclk);
      wr(ADDR_CONTROL, 8'h80);
      near(16'h0002);
      rd(ADDR_IRQ_FLAGS, d);
      chk(d, 8'h01);
      chk({7'h00, irq}, 8'h00);
      wr(ADDR_IRQ_ENABLE, 8'h01);
      repeat (2) @(posedge mclk);
      #1;
      chk({7'h00, irq}, 8'h01);
      wr(ADDR_IRQ_FLAGS, 8'h00);
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_HIGH, 8'hFF);
      wr(ADDR_LOW, 8'hFF);
      wr(3'h7, 8'h00, 3'h4);
      rd(ADDR_HIGH, d);
      chk(d, 8'h00);
      rd(ADDR_IRQ_FLAGS, d);
      chk(d, 8'h00);
      wr(ADDR_LOW, 8'h77, 3'h4);
      mode <= 4'($urandom_range(10, 0));
      rd(ADDR_LOW, d);
      chk(d, 8'h77);
      wr(3'h7, 8'h00, 3'h4);
      rd(ADDR_LOW, d);
      chk(d, 8'h77);
      mode <= MODE_SPECIAL_TRIGGER;
      use_t <= 1'b0;
      wr(3'h7, 8'h00, 3'h4);
      rd(ADDR_LOW, d);
      chk(d, 8'h77);
      use_t <= 1'b1;
      for (int s = 0; s < 2; s++) begin
         wr(ADDR_CONTROL, {5'h00, 1'(s), 2'h3});
         wr(ADDR_LOW, 8'h00);
         v = 16'($urandom_range(12, 2));
         edges(v[7:0]);
         rd(ADDR_LOW, d);
         chk(d, v[7:0]);
      end
      wr(ADDR_CONTROL, 8'h13);
      wr(ADDR_LOW, 8'h00);
      edges(8'h01);
      wr(ADDR_HIGH, 8'h00);
      edges(8'h01);
      rd(ADDR_LOW, d);
      chk(d, 8'h01);
      wr(ADDR_LOW, 8'h00);
      edges(8'h01);
      wr(ADDR_LOW, 8'h00);
      edges(8'h01);
      rd(ADDR_LOW, d);
      chk(d, 8'h00);
      wr(ADDR_CONTROL, 8'h08);
      repeat (20) @(posedge mclk);
      wr(ADDR_OSC_CONTROL, 8'h01);
      repeat (4) @(posedge mclk);
      rd(ADDR_CONTROL, d);
      chk(d, 8'h48);
      wr(3'h7, 8'h00, 3'h1);
      repeat (4) @(posedge mclk);
      #1;
      chk({5'h00, run, from_osc, gate}, 8'h06);
      wr(3'h7, 8'h00, 3'h2);
      wr(ADDR_OSC_CONTROL, 8'h81);
      wr(3'h7, 8'h00, 3'h1);
      repeat (4) @(posedge mclk);
      #1;
      chk({5'h00, run, from_osc, gate}, 8'h04);
      test_done;
   end
endmodule
`default_nettype wire
